/* File: lcdp_host_port.sv */
`timescale 1ns/100ps
module lcdp_host_port
    import lcdp_pkg::*;
#(
    parameter int OP_WAIT = OP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic register_select_i,
    input wire logic rd_wr_n_i,
    input wire logic enable_i,
    input wire logic [7:0] db_i,
    output logic [7:0] db_o,
    output logic db_oe_o,
    input wire logic [3:0] disp_pos_i,
    output logic [7:0] disp_char_o,
    output logic [6:0] disp_addr_o,
    output logic busy_o
);
    // reset release
    logic rst_s1_reg, rst_n;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // pin synchronisers; first stage feeds only the second
    logic en_s1_reg, en_s2_reg, en_d_reg;
    logic rs_s1_reg, rs_s2_reg, rw_s1_reg, rw_s2_reg;
    logic [7:0] db_s1_reg, db_s2_reg;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            en_d_reg <= 1'b0;
            rs_s1_reg <= 1'b0;
            rs_s2_reg <= 1'b0;
            rw_s1_reg <= 1'b0;
            rw_s2_reg <= 1'b0;
            db_s1_reg <= 8'h00;
            db_s2_reg <= 8'h00;
        end else begin
            en_s1_reg <= enable_i;
            en_s2_reg <= en_s1_reg;
            en_d_reg <= en_s2_reg;
            rs_s1_reg <= register_select_i;
            rs_s2_reg <= rs_s1_reg;
            rw_s1_reg <= rd_wr_n_i;
            rw_s2_reg <= rw_s1_reg;
            db_s1_reg <= db_i;
            db_s2_reg <= db_s1_reg;
        end
    end

    logic en_rise, en_fall;
    assign en_rise = en_s2_reg & ~en_d_reg;
    assign en_fall = ~en_s2_reg & en_d_reg;

    // block state
    lcdp_state_t state_reg, state_next;
    logic [OP_CNT_W-1:0] cnt_reg, cnt_next;
    logic [7:0] instruction_reg, instruction_next;
    logic [7:0] data_holding_reg, data_holding_next;
    logic [6:0] addr_pointer_reg, addr_pointer_next;
    logic glyph_sel_reg, glyph_sel_next;
    logic mode2_reg, mode2_next;
    logic up_reg, up_next;
    logic [3:0] shift_reg, shift_next;
    logic cyc_rs_reg, cyc_rs_next;
    logic cyc_rw_reg, cyc_rw_next;
    logic rd_pend_reg, rd_pend_next;
    logic [7:0] db_reg, db_next;
    logic db_oe_reg, db_oe_next;
    logic [7:0] disp_char_reg;
    logic [6:0] disp_addr_reg, disp_addr_next;
    logic busy_reg;

    // buffered writes and memory wiring
    lcdp_stream_if #(.W(BUF_W)) wr_in ();
    lcdp_stream_if #(.W(BUF_W)) wr_out ();
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] disp_cell;
    logic [3:0] scan_idx;
    logic busy_ind;
    logic host_wr;
    logic pop_word;

    // busy also covers queued writes and a pending prefetch
    assign busy_ind = (state_reg != ST_IDLE) | wr_out.valid | rd_pend_reg;
    assign host_wr = en_fall & ~cyc_rw_reg;

    // write goes to instruction or data register
    assign wr_in.valid = host_wr & (cyc_rs_reg | ~busy_ind);
    assign wr_in.data = {cyc_rs_reg, db_s2_reg};
    // a pending read prefetch is served before draining a write
    assign pop_word = (state_reg == ST_IDLE) & ~rd_pend_reg;
    assign wr_out.ready = pop_word;

    lcdp_skid_buf #(
        .W(BUF_W),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .in_s(wr_in),
        .out_s(wr_out)
    );

    // rotation: position p shows sequence entry p + shift
    assign scan_idx = disp_pos_i + shift_reg;

    lcdp_char_mem u_mem (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .we_i(mem_we),
        .glyph_i(glyph_sel_reg),
        .mode2_i(mode2_reg),
        .addr_i(addr_pointer_reg),
        .wdata_i(wr_out.data[7:0]),
        .rdata_o(mem_rdata),
        .disp_idx_i(scan_idx),
        .disp_char_o(disp_cell)
    );

    // bus side
    always_comb begin
        cyc_rs_next = cyc_rs_reg;
        cyc_rw_next = cyc_rw_reg;
        db_next = db_reg;
        db_oe_next = db_oe_reg;
        if (en_rise) begin
            // sample select and direction at rise
            cyc_rs_next = rs_s2_reg;
            cyc_rw_next = rw_s2_reg;
            db_oe_next = rw_s2_reg;
            if (rs_s2_reg) begin
                db_next = data_holding_reg;
            end else begin
                db_next = {busy_ind, addr_pointer_reg};
            end
        end else if (en_fall) begin
            db_oe_next = 1'b0;
        end
    end

    // operation engine
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        instruction_next = instruction_reg;
        data_holding_next = data_holding_reg;
        addr_pointer_next = addr_pointer_reg;
        glyph_sel_next = glyph_sel_reg;
        mode2_next = mode2_reg;
        up_next = up_reg;
        shift_next = shift_reg;
        rd_pend_next = rd_pend_reg;
        mem_we = 1'b0;
        // a data read finishing requests a prefetch
        if (en_fall & cyc_rw_reg & cyc_rs_reg) begin
            rd_pend_next = 1'b1;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (rd_pend_reg) begin
                    addr_pointer_next = step_addr(addr_pointer_reg, mode2_reg,
                                                  glyph_sel_reg, up_reg);
                    rd_pend_next = en_fall & cyc_rw_reg & cyc_rs_reg;
                    state_next = ST_FETCH;
                end else if (wr_out.valid) begin
                    state_next = ST_WAIT;
                    cnt_next = OP_CNT_W'(OP_WAIT);
                    if (wr_out.data[BUF_W-1]) begin
                        mem_we = 1'b1;
                        data_holding_next = wr_out.data[7:0];
                        addr_pointer_next = step_addr(addr_pointer_reg, mode2_reg,
                                                      glyph_sel_reg, up_reg);
                    end else begin
                        instruction_next = wr_out.data[7:0];
                        if (wr_out.data[INS_SET_DISP_BIT]) begin
                            addr_pointer_next = wr_out.data[6:0];
                            glyph_sel_next = 1'b0;
                            state_next = ST_FETCH;
                        end else if (wr_out.data[INS_SET_GLYPH_BIT]) begin
                            addr_pointer_next = {1'b0, wr_out.data[5:0]};
                            glyph_sel_next = 1'b1;
                            state_next = ST_FETCH;
                        end else if (wr_out.data[INS_FUNC_BIT]) begin
                            mode2_next = wr_out.data[FUNC_MODE_BIT];
                        end else if (wr_out.data[INS_SHIFT_BIT]) begin
                            if (wr_out.data[SHIFT_DISP_BIT]) begin
                                shift_next = wr_out.data[SHIFT_RIGHT_BIT] ?
                                             shift_reg - 4'h1 : shift_reg + 4'h1;
                            end
                        end else if (wr_out.data[INS_ENTRY_BIT]) begin
                            up_next = wr_out.data[ENTRY_UP_BIT];
                        end
                    end
                end
            end
            ST_FETCH: begin
                // fetch addressed byte into data register
                data_holding_next = mem_rdata;
                cnt_next = OP_CNT_W'(OP_WAIT);
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                // clear busy once the operation time ends
                if (cnt_reg <= OP_CNT_W'(1)) begin
                    cnt_next = '0;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - OP_CNT_W'(1);
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // address shown at the scanned position
    assign disp_addr_next = index_addr(scan_idx, mode2_reg);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            instruction_reg <= 8'h00;
            data_holding_reg <= 8'h00;
            addr_pointer_reg <= 7'h00;
            glyph_sel_reg <= 1'b0;
            mode2_reg <= 1'b0;
            up_reg <= 1'b1;
            shift_reg <= 4'h0;
            cyc_rs_reg <= 1'b0;
            cyc_rw_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            db_reg <= 8'h00;
            db_oe_reg <= 1'b0;
            disp_char_reg <= 8'h00;
            disp_addr_reg <= 7'h00;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            instruction_reg <= instruction_next;
            data_holding_reg <= data_holding_next;
            addr_pointer_reg <= addr_pointer_next;
            glyph_sel_reg <= glyph_sel_next;
            mode2_reg <= mode2_next;
            up_reg <= up_next;
            shift_reg <= shift_next;
            cyc_rs_reg <= cyc_rs_next;
            cyc_rw_reg <= cyc_rw_next;
            rd_pend_reg <= rd_pend_next;
            db_reg <= db_next;
            db_oe_reg <= db_oe_next;
            disp_char_reg <= disp_cell;
            disp_addr_reg <= disp_addr_next;
            busy_reg <= busy_ind;
        end
    end

    assign db_o = db_reg;
    assign db_oe_o = db_oe_reg;
    assign disp_char_o = disp_char_reg;
    assign disp_addr_o = disp_addr_reg;
    assign busy_o = busy_reg;
endmodule

/* File: lcdp_pkg.sv */
package lcdp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DISP_DEPTH = 16;
    localparam int GLYPH_DEPTH = 64;
    localparam int CLK_PERIOD_NS = 100;
    localparam int OP_TIME_NS = 40000;
    localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OP_CNT_W = 16;
    localparam logic [7:0] MEM_RESET_VAL = 8'h20;
    // status read layout
    localparam int STAT_BUSY_BIT = 7;
    // instruction decode: leading one picks the command
    localparam int INS_SET_DISP_BIT = 7;
    localparam int INS_SET_GLYPH_BIT = 6;
    localparam int INS_FUNC_BIT = 5;
    localparam int INS_SHIFT_BIT = 4;
    localparam int INS_ENTRY_BIT = 2;
    localparam int FUNC_MODE_BIT = 2;
    localparam int SHIFT_DISP_BIT = 3;
    localparam int SHIFT_RIGHT_BIT = 2;
    localparam int ENTRY_UP_BIT = 1;
    // buffered word: bit 8 flags a data-register write
    localparam int BUF_W = 9;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT = 2'b10
    } lcdp_state_t;

    function automatic logic disp_valid(input logic [6:0] addr, input logic mode2);
        disp_valid = mode2 ? (addr[5:3] == 3'h0) : (addr[6:4] == 3'h0);
    endfunction

    function automatic logic [3:0] disp_index(input logic [6:0] addr, input logic mode2);
        disp_index = mode2 ? {addr[6], addr[2:0]} : addr[3:0];
    endfunction

    function automatic logic [6:0] index_addr(input logic [3:0] idx, input logic mode2);
        index_addr = mode2 ? {idx[3], 3'h0, idx[2:0]} : {3'h0, idx};
    endfunction

    function automatic logic [6:0] step_addr(input logic [6:0] addr, input logic mode2,
                                             input logic glyph, input logic up);
        logic [3:0] idx;
        logic [5:0] g;
        idx = disp_index(addr, mode2);
        g = addr[5:0];
        if (glyph) begin
            step_addr = {1'b0, up ? g + 6'h01 : g - 6'h01};
        end else begin
            step_addr = index_addr(up ? idx + 4'h1 : idx - 4'h1, mode2);
        end
    endfunction
endpackage

/* File: lcdp_stream_if.sv */
`timescale 1ns/100ps
interface lcdp_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: lcdp_skid_buf.sv */
`timescale 1ns/100ps
module lcdp_skid_buf #(
    parameter int W = 9,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    lcdp_stream_if.snk in_s,
    lcdp_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] slot_reg [DEPTH];
    logic [W-1:0] slot_next [DEPTH];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [PW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_s.ready = (cnt_reg != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data = slot_reg[rp_reg];
    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;

    always_comb begin
        slot_next = slot_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            slot_next[wp_reg] = in_s.data;
            wp_next = (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + PW'(1);
        end
        if (pop) begin
            rp_next = (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + PW'(1);
        end
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                slot_reg[i] <= '0;
            end
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            slot_reg <= slot_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

/* File: lcdp_char_mem.sv */
`timescale 1ns/100ps
module lcdp_char_mem
    import lcdp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic glyph_i,
    input wire logic mode2_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic [3:0] disp_idx_i,
    output logic [7:0] disp_char_o
);
    logic [7:0] disp_reg [DISP_DEPTH];
    logic [7:0] disp_next [DISP_DEPTH];
    logic [7:0] glyph_reg [GLYPH_DEPTH];
    logic [7:0] glyph_next [GLYPH_DEPTH];
    logic hit;
    logic [3:0] idx;

    assign idx = disp_index(addr_i, mode2_i);
    assign hit = disp_valid(addr_i, mode2_i);
    // unmapped display addresses read as zero
    assign rdata_o = glyph_i ? glyph_reg[addr_i[5:0]] : (hit ? disp_reg[idx] : 8'h00);
    assign disp_char_o = disp_reg[disp_idx_i];

    always_comb begin
        disp_next = disp_reg;
        glyph_next = glyph_reg;
        if (we_i && glyph_i) begin
            glyph_next[addr_i[5:0]] = wdata_i;
        end else if (we_i && hit) begin
            disp_next[idx] = wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DISP_DEPTH; i++) begin
                disp_reg[i] <= MEM_RESET_VAL;
            end
            for (int j = 0; j < GLYPH_DEPTH; j++) begin
                glyph_reg[j] <= 8'h00;
            end
        end else begin
            disp_reg <= disp_next;
            glyph_reg <= glyph_next;
        end
    end
endmodule

/* File: lcdp_host_port_chk.sv */
`timescale 1ns/100ps
module lcdp_host_port_chk #(
    parameter int OP_WAIT = 400
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic register_select_i,
    input wire logic rd_wr_n_i,
    input wire logic enable_i,
    input wire logic [7:0] db_i,
    input wire logic [7:0] db_o,
    input wire logic db_oe_o,
    input wire logic [3:0] disp_pos_i,
    input wire logic [7:0] disp_char_o,
    input wire logic [6:0] disp_addr_o,
    input wire logic busy_o
);
    logic [15:0] busy_len_reg;
    logic [15:0] busy_len_next;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    always_comb begin
        busy_len_next = busy_o ? busy_len_reg + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_len_reg <= 16'h0000;
        end else begin
            busy_len_reg <= busy_len_next;
        end
    end

    oe_on_read_a: assert property ($rose(enable_i) && rd_wr_n_i |-> ##[2:4] db_oe_o)
        else $error("read strobe did not drive the bus");
    oe_cause_a: assert property ($rose(db_oe_o) |-> $past(enable_i, 2) && $past(rd_wr_n_i, 2))
        else $error("bus driven without a read strobe");
    oe_release_a: assert property ($fell(enable_i) |-> ##[2:4] !db_oe_o)
        else $error("bus not released after strobe fall");
    read_hold_a: assert property (db_oe_o && $past(db_oe_o) |-> $stable(db_o))
        else $error("read data changed while driven");
    no_write_drive_a: assert property ((!rd_wr_n_i)[*2] |-> !db_oe_o)
        else $error("bus driven during a write");
    busy_on_write_a: assert property ($fell(enable_i) && !rd_wr_n_i |-> ##[1:6] busy_o)
        else $error("write did not raise busy");
    busy_min_a: assert property ($fell(busy_o) |-> busy_len_reg >= 16'(OP_WAIT))
        else $error("busy cleared too early");
    busy_max_a: assert property (busy_len_reg < 16'(4 * OP_WAIT + 16))
        else $error("busy never cleared");
    disp_map_a: assert property (disp_addr_o[5:4] == 2'h0 && !(disp_addr_o[6] && disp_addr_o[3]))
        else $error("display address outside both maps");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n_i |-> !db_oe_o && !busy_o)
        else $error("outputs active in reset");

    cover property (db_oe_o && !register_select_i);
    cover property (db_oe_o && register_select_i);
    cover property ($fell(busy_o));
endmodule

bind lcdp_host_port lcdp_host_port_chk #(.OP_WAIT(OP_WAIT)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .register_select_i(register_select_i),
    .rd_wr_n_i(rd_wr_n_i), .enable_i(enable_i), .db_i(db_i), .db_o(db_o),
    .db_oe_o(db_oe_o), .disp_pos_i(disp_pos_i), .disp_char_o(disp_char_o),
    .disp_addr_o(disp_addr_o), .busy_o(busy_o)
);

/* File: lcdp_host_model.sv */
`timescale 1ns/100ps
module lcdp_host_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_db_i,
    input wire logic dev_oe_i,
    output logic rs_o,
    output logic rw_o,
    output logic en_o,
    output logic [7:0] db_o
);
    logic drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last_v = 8'h00;

    initial begin
        rs_o = 1'b0;
        rw_o = 1'b1;
        en_o = 1'b0;
    end

    // released bus floats: show inverse of last level, never a stale copy
    assign db_o = dev_oe_i ? dev_db_i : (drv ? wd : ~last_v);

    always @(posedge clk_i) begin
        if (dev_oe_i || drv) begin
            last_v <= db_o;
        end
    end

    // select and direction settle with the strobe
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_i);
        rs_o = rs;
        rw_o = rw;
        drv = !rw;
        wd = d;
        en_o = 1'b1;
        repeat (6) @(negedge clk_i);
        q = db_o;
        en_o = 1'b0;
        repeat (2) @(negedge clk_i);
        drv = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic wait_idle(output logic [7:0] st);
        st = 8'hff;
        for (int i = 0; i < 200 && st[7] !== 1'b0; i++) begin
            xfer(1'b0, 1'b1, 8'h00, st);
        end
    endtask
endmodule

/* File: test_char_lcd_host_register_port.sv */
`timescale 1ns/100ps
module test_char_lcd_host_register_port;
    import lcdp_pkg::*;
    localparam int WAIT_N = 40;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic rs, rw, en, db_oe, busy_o;
    logic [7:0] db_i, db_o, rd, st, d, disp_char_o;
    logic [7:0] dmem [0:15];
    logic [3:0] disp_pos_i;
    logic [6:0] disp_addr_o;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    lcdp_host_port #(.OP_WAIT(WAIT_N)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .register_select_i(rs), .rd_wr_n_i(rw),
        .enable_i(en), .db_i(db_i), .db_o(db_o), .db_oe_o(db_oe),
        .disp_pos_i(disp_pos_i), .disp_char_o(disp_char_o),
        .disp_addr_o(disp_addr_o), .busy_o(busy_o)
    );

    lcdp_host_model u_host (
        .clk_i(clk_i), .dev_db_i(db_o), .dev_oe_i(db_oe), .rs_o(rs), .rw_o(rw),
        .en_o(en), .db_o(db_i)
    );

    always #50 clk_i = ~clk_i;

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard well above the expected run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic op(input logic r, input logic w, input logic [7:0] v);
        u_host.xfer(r, w, v, rd);
        u_host.wait_idle(st);
        check({st[7], 7'h00}, 8'h00);
    endtask

    task automatic status(input logic [7:0] e);
        u_host.xfer(1'b0, 1'b1, 8'h00, rd);
        check(rd, e);
    endtask

    function automatic logic [6:0] seq_addr(input int p, input int off, input logic m2);
        logic [3:0] i;
        i = 4'((p + off) % 16);
        return m2 ? {i[3], 3'h0, i[2:0]} : {3'h0, i};
    endfunction

    task automatic scan(input int off, input logic m2);
        for (int p = 0; p < 16; p++) begin
            disp_pos_i = 4'(p);
            repeat (3) @(negedge clk_i);
            check({1'b0, disp_addr_o}, {1'b0, seq_addr(p, off, m2)});
            check(disp_char_o, dmem[(p + off) % 16]);
        end
    endtask

    initial begin
        disp_pos_i = 4'h0;
        void'($urandom(51));
        // lower reset after time zero so the asynchronous clear sees a real edge
        #10;
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check({7'h00, busy_o}, 8'h00);
        op(1'b0, 1'b0, 8'h06);
        op(1'b0, 1'b0, 8'h20);
        op(1'b0, 1'b0, 8'h80);
        for (int i = 0; i < 16; i++) begin
            dmem[i] = 8'($urandom);
            op(1'b1, 1'b0, dmem[i]);
        end
        status(8'h00);
        op(1'b0, 1'b0, 8'h80);
        for (int i = 0; i < 16; i++) begin
            op(1'b1, 1'b1, 8'h00);
            check(rd, dmem[i]);
        end
        scan(0, 1'b0);
        $display("test mode_one done");
        op(1'b0, 1'b0, 8'h24);
        op(1'b0, 1'b0, 8'h87);
        dmem[7] = 8'($urandom);
        op(1'b1, 1'b0, dmem[7]);
        status(8'h40);
        op(1'b0, 1'b0, 8'hc7);
        dmem[15] = 8'($urandom);
        op(1'b1, 1'b0, dmem[15]);
        status(8'h00);
        scan(0, 1'b1);
        $display("test mode_two done");
        op(1'b0, 1'b0, 8'h18);
        scan(1, 1'b1);
        op(1'b0, 1'b0, 8'h1c);
        op(1'b0, 1'b0, 8'h1c);
        scan(15, 1'b1);
        op(1'b0, 1'b0, 8'h20);
        scan(15, 1'b0);
        $display("test shift done");
        op(1'b0, 1'b0, 8'h24);
        op(1'b0, 1'b0, 8'h04);
        op(1'b0, 1'b0, 8'h80);
        dmem[0] = 8'($urandom);
        op(1'b1, 1'b0, dmem[0]);
        status(8'h47);
        op(1'b0, 1'b0, 8'h06);
        op(1'b0, 1'b0, 8'h7f);
        d = 8'($urandom);
        op(1'b1, 1'b0, d);
        status(8'h00);
        op(1'b0, 1'b0, 8'h7f);
        op(1'b1, 1'b1, 8'h00);
        check(rd, d);
        $display("test pointer done");
        // second instruction lands while busy and must be dropped
        u_host.xfer(1'b0, 1'b0, 8'h85, rd);
        status(8'h85);
        u_host.xfer(1'b0, 1'b0, 8'h8a, rd);
        u_host.wait_idle(st);
        status(8'h05);
        d = 8'($urandom);
        u_host.xfer(1'b1, 1'b0, d, rd);
        u_host.xfer(1'b1, 1'b0, ~d, rd);
        u_host.wait_idle(st);
        status(8'h07);
        op(1'b0, 1'b0, 8'h85);
        op(1'b1, 1'b1, 8'h00);
        check(rd, d);
        op(1'b1, 1'b1, 8'h00);
        check(rd, ~d);
        $display("test busy done");
        complete_run();
    end
endmodule
